// File: logic/link_error_rate_monitor.sv
// Error-rate monitor for one link port with an Avalon-MM register slave.
// Assumes error pulses and link-state levels come from logic on CORE_CLK.
//
// Behaviour
// - Flag can only set while the monitor enable bit is one.
// - Flag is sticky, cleared only by software writing one, resets to zero.
// - Threshold field bits 7:0, reset 0xff, minimum errors to judge unreliable.
// - Period field bits 31:8 gives the window length in microseconds.
// - Read-only eight-bit error counter, saturating instead of wrapping.
// - Error counter clears on retrain request or link passing through Detect.
// - Both counters clear when enable rises from zero to one.
// - Both counters hold once the link is judged unreliable, unless a retrain request, Detect or enable rise clears them.
// - Error counter restarts from zero when period count equals the period.
// - Period counter restarts from zero when it equals the period.
// - Counters keep running while the monitor is disabled.
// - Read-only 24-bit period counter advances once per microsecond, saturating.
// - Period counter clears on retrain request or full retrain through Detect.
// - Sticky enable bit turns the monitor on, resets to zero.
// - Type bit selects CRC errors or port-initiated L0-to-Recovery transitions.
`timescale 1ns/10ps
`default_nettype none
module link_error_rate_monitor
	import link_monitor_pkg::*;
#(
	parameter int TICK_CYCLES = US_CYCLES
) (
	input  wire logic        CORE_CLK,
	input  wire logic        SRST,
	input  wire logic [15:0] ADDRESS,
	input  wire logic        READ,
	input  wire logic        WRITE,
	input  wire logic [31:0] WRITEDATA,
	input  wire logic [3:0]  BYTEENABLE,
	output var  logic [31:0] READDATA,
	output var  logic        WAITREQUEST,
	output var  logic        IRQ,
	output var  logic        UNRELIABLE_LINK,
	input  wire logic        LCRC_ERROR,
	input  wire logic        RECOVERY_ERROR,
	input  wire logic        LINK_RETRAIN_REQUEST,
	input  wire logic        LINK_IN_DETECT
);

	function automatic logic [31:0] merge_bytes(input logic [31:0] old_val,
		input logic [31:0] new_val, input logic [3:0] be);
		logic [31:0] res;
		res = old_val;
		for (int i = 0; i < 4; i++) begin
			if (be[i]) begin
				res[i*8 +: 8] = new_val[i*8 +: 8];
			end
		end
		return res;
	endfunction : merge_bytes

	function automatic logic [23:0] inc_sat(input logic [23:0] value, input logic [23:0] max);
		return (value == max) ? value : value + 24'h000001;
	endfunction : inc_sat

	logic                  waitrequest_r;
	logic [31:0]           readdata_r;
	logic                  irq_r;
	logic                  enable_r;
	logic                  err_type_r;
	logic                  enable_prev_r;
	logic                  flag_r;
	logic                  flag_nxt;
	logic [THRESH_W-1:0]   threshold_r;
	logic [PERIOD_W-1:0]   period_r;
	logic [THRESH_W-1:0]   err_count_r;
	logic [THRESH_W-1:0]   err_count_nxt;
	logic [PERIOD_W-1:0]   window_count_r;
	logic [PERIOD_W-1:0]   window_count_nxt;
	logic [DIV_W-1:0]      div_r;
	logic                  tick_r;
	logic [IRQ_W-1:0]      irq_status_r;
	logic [IRQ_W-1:0]      irq_status_nxt;
	logic [IRQ_W-1:0]      irq_mask_r;

	wire                   access_ack;
	wire                   wr_ack;
	wire                   hit_ctrl;
	wire                   hit_flag;
	wire                   hit_count;
	wire                   hit_thresh;
	wire                   hit_irq_st;
	wire                   hit_irq_mk;
	wire [31:0]            rd_mux;
	wire [31:0]            thresh_word;
	wire [31:0]            thresh_new;
	wire [31:0]            ctrl_new;
	wire [31:0]            mask_new;
	wire                   err_event;
	wire                   enable_rise;
	wire                   counters_clear;
	wire                   window_end;
	wire                   judged;
	wire                   flag_set;
	wire                   flag_clear;
	wire [IRQ_W-1:0]       irq_set;
	wire [IRQ_W-1:0]       irq_clear;
	wire                   ctrl_wr;
	wire                   thresh_wr;
	wire                   mask_wr;
	wire [PERIOD_W-1:0]    err_count_inc;

	// One answer per request: waitrequest drops for exactly one cycle
	assign access_ack  = (READ | WRITE) & waitrequest_r;
	assign wr_ack      = WRITE & ~waitrequest_r;

	assign hit_ctrl    = (ADDRESS == MONITOR_CONTROL_OFS);
	assign hit_flag    = (ADDRESS == LINK_UNRELIABLE_OFS);
	assign hit_count   = (ADDRESS == LINK_ERR_COUNT_OFS);
	assign hit_thresh  = (ADDRESS == ERR_RATE_THRESH_OFS);
	assign hit_irq_st  = (ADDRESS == IRQ_STATUS_OFS);
	assign hit_irq_mk  = (ADDRESS == IRQ_MASK_OFS);
	assign ctrl_wr     = wr_ack & hit_ctrl;
	assign thresh_wr   = wr_ack & hit_thresh;
	assign mask_wr     = wr_ack & hit_irq_mk;

	assign thresh_word = {period_r, threshold_r};
	assign thresh_new  = merge_bytes(thresh_word, WRITEDATA, BYTEENABLE);
	assign ctrl_new    = merge_bytes({30'h0, err_type_r, enable_r}, WRITEDATA, BYTEENABLE);
	assign mask_new    = merge_bytes({30'h0, irq_mask_r}, WRITEDATA, BYTEENABLE);

	// Unmapped addresses read as zero and ignore writes
	assign rd_mux = hit_ctrl   ? {30'h0, err_type_r, enable_r} :
	                hit_flag   ? {31'h0, flag_r} :
	                hit_count  ? {window_count_r, err_count_r} :
	                hit_thresh ? thresh_word :
	                hit_irq_st ? {30'h0, irq_status_r} :
	                hit_irq_mk ? {30'h0, irq_mask_r} :
	                32'h0;

	// Event selection and counter control
	assign err_event      = err_type_r ? RECOVERY_ERROR : LCRC_ERROR;
	assign enable_rise    = enable_r & ~enable_prev_r;
	assign counters_clear = LINK_RETRAIN_REQUEST | LINK_IN_DETECT | enable_rise;
	assign window_end     = (window_count_r == period_r);
	assign judged         = flag_r;
	assign err_count_inc  = inc_sat(PERIOD_W'(err_count_r), PERIOD_W'({THRESH_W{1'b1}}));

	// Zero threshold or period is not guarded; software must avoid it
	assign flag_set   = enable_r & (err_count_r >= threshold_r);
	assign flag_clear = wr_ack & hit_flag & BYTEENABLE[0] & WRITEDATA[FLAG_BIT];

	assign irq_set[IRQ_UNRELIABLE_BIT] = flag_set & ~flag_r;
	assign irq_set[IRQ_WINDOW_BIT]     = window_end & ~judged & ~counters_clear;
	assign irq_clear = (wr_ack & hit_irq_st & BYTEENABLE[0]) ? WRITEDATA[IRQ_W-1:0] : '0;

	always_comb begin
		// Set beats a simultaneous software clear
		flag_nxt = flag_set | (flag_r & ~flag_clear);
		irq_status_nxt = irq_set | (irq_status_r & ~irq_clear);
	end

	always_comb begin
		// Disable does not stop counting, only the flag
		if (counters_clear) begin
			err_count_nxt    = '0;
			window_count_nxt = '0;
		end else if (judged) begin
			err_count_nxt    = err_count_r;
			window_count_nxt = window_count_r;
		end else if (window_end) begin
			err_count_nxt    = '0;
			window_count_nxt = '0;
		end else begin
			err_count_nxt    = err_count_r;
			window_count_nxt = window_count_r;
			if (err_event) begin
				err_count_nxt = err_count_inc[THRESH_W-1:0];
			end
			if (tick_r) begin
				window_count_nxt = inc_sat(window_count_r, {PERIOD_W{1'b1}});
			end
		end
	end

	// Microsecond tick; a one-cycle pulse, no second clock
	always_ff @(posedge CORE_CLK) begin
		if (SRST || div_r == DIV_W'(TICK_CYCLES - 1)) begin
			div_r <= '0;
		end else begin
			div_r <= div_r + DIV_W'(1);
		end
	end

	always_ff @(posedge CORE_CLK) begin
		tick_r <= ~SRST & (div_r == DIV_W'(TICK_CYCLES - 1));
	end

	always_ff @(posedge CORE_CLK) begin
		if (SRST) begin
			waitrequest_r <= 1'b1;
		end else begin
			waitrequest_r <= ~access_ack;
		end
	end

	// Holds the last answer so a late sampler still sees it
	always_ff @(posedge CORE_CLK) begin
		if (SRST) begin
			readdata_r <= '0;
		end else if (access_ack) begin
			readdata_r <= rd_mux;
		end
	end

	// Sticky fields share the only reset available here
	always_ff @(posedge CORE_CLK) begin
		if (SRST) begin
			enable_r <= 1'b0;
		end else if (ctrl_wr) begin
			enable_r <= ctrl_new[CTRL_EN_BIT];
		end
	end

	always_ff @(posedge CORE_CLK) begin
		if (SRST) begin
			err_type_r <= 1'b0;
		end else if (ctrl_wr) begin
			err_type_r <= ctrl_new[CTRL_TYPE_BIT];
		end
	end

	always_ff @(posedge CORE_CLK) begin
		if (SRST) begin
			threshold_r <= THRESH_RESET;
		end else if (thresh_wr) begin
			threshold_r <= thresh_new[THRESH_LSB +: THRESH_W];
		end
	end

	always_ff @(posedge CORE_CLK) begin
		if (SRST) begin
			period_r <= PERIOD_RESET;
		end else if (thresh_wr) begin
			period_r <= thresh_new[PERIOD_LSB +: PERIOD_W];
		end
	end

	always_ff @(posedge CORE_CLK) begin
		if (SRST) begin
			irq_mask_r <= '0;
		end else if (mask_wr) begin
			irq_mask_r <= mask_new[IRQ_W-1:0];
		end
	end

	always_ff @(posedge CORE_CLK) begin
		if (SRST) begin
			enable_prev_r <= 1'b0;
		end else begin
			enable_prev_r <= enable_r;
		end
	end

	always_ff @(posedge CORE_CLK) begin
		if (SRST) begin
			flag_r <= 1'b0;
		end else begin
			flag_r <= flag_nxt;
		end
	end

	always_ff @(posedge CORE_CLK) begin
		if (SRST) begin
			err_count_r <= '0;
		end else begin
			err_count_r <= err_count_nxt;
		end
	end

	always_ff @(posedge CORE_CLK) begin
		if (SRST) begin
			window_count_r <= '0;
		end else begin
			window_count_r <= window_count_nxt;
		end
	end

	always_ff @(posedge CORE_CLK) begin
		if (SRST) begin
			irq_status_r <= '0;
		end else begin
			irq_status_r <= irq_status_nxt;
		end
	end

	// Built from the next status so the line moves with the status bit
	always_ff @(posedge CORE_CLK) begin
		if (SRST) begin
			irq_r <= 1'b0;
		end else begin
			irq_r <= |(irq_status_nxt & irq_mask_r);
		end
	end

	assign READDATA        = readdata_r;
	assign WAITREQUEST     = waitrequest_r;
	assign IRQ             = irq_r;
	assign UNRELIABLE_LINK = flag_r;

endmodule : link_error_rate_monitor
`default_nettype wire

// File: logic/link_monitor_pkg.sv
// Constants for the link error-rate monitor: register map, fields, resets, timing.
// Assumes a 50 MHz core clock and byte addresses on a 32-bit register bus.
package link_monitor_pkg;
	localparam logic [15:0] MONITOR_CONTROL_OFS  = 16'h0560;
	localparam logic [15:0] LINK_UNRELIABLE_OFS  = 16'h0564;
	localparam logic [15:0] LINK_ERR_COUNT_OFS   = 16'h056c;
	localparam logic [15:0] ERR_RATE_THRESH_OFS  = 16'h5680;
	localparam logic [15:0] IRQ_STATUS_OFS       = 16'h0570;
	localparam logic [15:0] IRQ_MASK_OFS         = 16'h0574;

	localparam int CTRL_EN_BIT                   = 0;
	localparam int CTRL_TYPE_BIT                 = 1;
	localparam int FLAG_BIT                      = 0;
	localparam int THRESH_LSB                    = 0;
	localparam int THRESH_W                      = 8;
	localparam int PERIOD_LSB                    = 8;
	localparam int PERIOD_W                      = 24;
	localparam int IRQ_W                         = 2;
	localparam int IRQ_UNRELIABLE_BIT            = 0;
	localparam int IRQ_WINDOW_BIT                = 1;

	localparam logic [7:0]  THRESH_RESET         = 8'hff;
	localparam logic [23:0] PERIOD_RESET         = 24'h0fffff;

	localparam int US_NS                         = 1000;
	localparam int CLK_PERIOD_NS                 = 20;
	localparam int US_CYCLES                     = (US_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int DIV_W                         = 8;
endpackage : link_monitor_pkg

// File: testbench/link_monitor_sva.sv
// Port checker for the link error-rate monitor.
// Sees only the top ports; bound from the testbench file.
`timescale 1ns/10ps
`default_nettype none
module link_monitor_sva
	import link_monitor_pkg::*;
(
	input wire logic        CORE_CLK,
	input wire logic        SRST,
	input wire logic [15:0] ADDRESS,
	input wire logic        READ,
	input wire logic        WRITE,
	input wire logic [31:0] WRITEDATA,
	input wire logic [3:0]  BYTEENABLE,
	input wire logic [31:0] READDATA,
	input wire logic        WAITREQUEST,
	input wire logic        IRQ,
	input wire logic        UNRELIABLE_LINK,
	input wire logic        LCRC_ERROR,
	input wire logic        RECOVERY_ERROR,
	input wire logic        LINK_RETRAIN_REQUEST,
	input wire logic        LINK_IN_DETECT
);
	default clocking @(posedge CORE_CLK); endclocking
	default disable iff (SRST);
	logic [2:0] age_r;
	wire logic ack_w = WRITE && !WAITREQUEST;
	wire logic clr_w = ack_w && ADDRESS == LINK_UNRELIABLE_OFS && WRITEDATA[0] && BYTEENABLE[0];
	wire logic ev_w = ack_w || ((LCRC_ERROR || RECOVERY_ERROR) && !LINK_RETRAIN_REQUEST);
	// Saturates so an old cause never looks fresh again
	wire logic [2:0] age_nxt = ev_w ? 3'h0 : age_r + {2'h0, age_r != 3'h7};
	always_ff @(posedge CORE_CLK) age_r <= SRST ? 3'h7 : age_nxt;
	sequence req_s;
		(READ || WRITE) && WAITREQUEST;
	endsequence
	sequence ack_s;
		!WAITREQUEST ##1 WAITREQUEST;
	endsequence
	a_reset_idle: assert property (disable iff (1'b0)
		SRST |=> WAITREQUEST && !IRQ && !UNRELIABLE_LINK && READDATA == 32'h0)
		else $error("outputs busy after reset");
	a_bus_ack: assert property (req_s |=> ack_s)
		else $error("request not answered in one cycle");
	a_no_stray: assert property (!(READ || WRITE) && WAITREQUEST |=> WAITREQUEST)
		else $error("answer without request");
	a_ack_cause: assert property ($fell(WAITREQUEST) |-> $past(READ || WRITE))
		else $error("acknowledge without request");
	a_rdata_hold: assert property ($changed(READDATA) |-> !WAITREQUEST)
		else $error("read data moved outside an answer");
	a_flag_sticky: assert property (UNRELIABLE_LINK && !clr_w && !$past(clr_w) |=> UNRELIABLE_LINK)
		else $error("flag dropped without clear");
	a_flag_cause: assert property ($rose(UNRELIABLE_LINK) |-> age_r <= 3'h4)
		else $error("flag set without error or write");
	a_irq_cause: assert property ($fell(IRQ) |-> $past(ack_w) || $past(ack_w, 2))
		else $error("irq dropped without write");
endmodule : link_monitor_sva
`default_nettype wire

// File: testbench/testbench.sv
// Directed register and link scenarios for the error-rate monitor.
// Drives all ports itself; tick divider shortened to two cycles.
`timescale 1ns/10ps
`default_nettype none
module testbench;
	import link_monitor_pkg::*;
	localparam logic [31:0] all_ones = 32'hffffffff;
	logic CORE_CLK, SRST, READ, WRITE, WAITREQUEST, IRQ, UNRELIABLE_LINK;
	logic LCRC_ERROR, RECOVERY_ERROR, LINK_RETRAIN_REQUEST, LINK_IN_DETECT;
	logic [15:0] ADDRESS;
	logic [31:0] WRITEDATA, READDATA, rd;
	logic [3:0] BYTEENABLE;
	int num_errors, total_checks;
	link_error_rate_monitor #(.TICK_CYCLES(2)) u_link_error_rate_monitor (
		.CORE_CLK(CORE_CLK), .SRST(SRST), .ADDRESS(ADDRESS), .READ(READ), .WRITE(WRITE),
		.WRITEDATA(WRITEDATA), .BYTEENABLE(BYTEENABLE), .READDATA(READDATA),
		.WAITREQUEST(WAITREQUEST), .IRQ(IRQ), .UNRELIABLE_LINK(UNRELIABLE_LINK),
		.LCRC_ERROR(LCRC_ERROR), .RECOVERY_ERROR(RECOVERY_ERROR),
		.LINK_RETRAIN_REQUEST(LINK_RETRAIN_REQUEST), .LINK_IN_DETECT(LINK_IN_DETECT));
	initial begin
		CORE_CLK = 1'b0;
		forever #10 CORE_CLK = ~CORE_CLK;
	end
	task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
		total_checks++;
		if (g !== e) begin
			num_errors++;
			$display("unexpected %s expected %h seen %h", n, e, g);
		end
	endtask : chk
	// Request held until the acknowledge edge
	task automatic bus(input logic w, input logic [15:0] a, input logic [31:0] d);
		@(posedge CORE_CLK);
		ADDRESS <= a;
		WRITEDATA <= d;
		WRITE <= w;
		READ <= !w;
		do @(posedge CORE_CLK); while (WAITREQUEST !== 1'b0);
		rd = READDATA;
		WRITE <= 1'b0;
		READ <= 1'b0;
	endtask : bus
	task automatic rdc(input logic [15:0] a, input logic [31:0] m, e, input string n);
		bus(1'b0, a, 32'h0);
		chk(n, e, rd & m);
	endtask : rdc
	task automatic errs(input int n, input logic r);
		repeat (n) begin
			@(posedge CORE_CLK);
			LCRC_ERROR <= !r;
			RECOVERY_ERROR <= r;
			@(posedge CORE_CLK);
			LCRC_ERROR <= 1'b0;
			RECOVERY_ERROR <= 1'b0;
		end
	endtask : errs
	task automatic t_reset;
		rdc(ERR_RATE_THRESH_OFS, all_ones, {PERIOD_RESET, THRESH_RESET}, "threshold");
		rdc(LINK_UNRELIABLE_OFS, all_ones, 32'h0, "status");
		rdc(MONITOR_CONTROL_OFS, 32'h3, 32'h0, "control");
		bus(1'b1, 16'h0100, all_ones);
		rdc(16'h0100, all_ones, 32'h0, "unmapped");
	endtask : t_reset
	task automatic t_sat;
		errs(300, 1'b0);
		bus(1'b1, LINK_ERR_COUNT_OFS, 32'h0);
		rdc(LINK_ERR_COUNT_OFS, 32'hff, 32'hff, "saturated count");
		@(negedge CORE_CLK);
		chk("flag disabled", 32'h0, {31'h0, UNRELIABLE_LINK});
	endtask : t_sat
	task automatic t_type;
		bus(1'b1, MONITOR_CONTROL_OFS, 32'h2);
		LINK_RETRAIN_REQUEST <= 1'b1;
		rdc(LINK_ERR_COUNT_OFS, all_ones, 32'h0, "retrain counters");
		LINK_RETRAIN_REQUEST <= 1'b0;
		errs(1, 1'b0);
		errs(2, 1'b1);
		rdc(LINK_ERR_COUNT_OFS, 32'hff, 32'h2, "recovery count");
		LINK_IN_DETECT <= 1'b1;
		rdc(LINK_ERR_COUNT_OFS, all_ones, 32'h0, "detect counters");
		LINK_IN_DETECT <= 1'b0;
		errs(1, 1'b1);
	endtask : t_type
	task automatic t_flag;
		bus(1'b1, ERR_RATE_THRESH_OFS, {24'h0003e8, 8'h02});
		bus(1'b1, IRQ_MASK_OFS, 32'h1);
		bus(1'b1, MONITOR_CONTROL_OFS, 32'h1);
		rdc(LINK_ERR_COUNT_OFS, 32'hff, 32'h0, "enable count");
		errs(2, 1'b0);
		repeat (3) @(posedge CORE_CLK);
		@(negedge CORE_CLK);
		chk("flag", 32'h1, {31'h0, UNRELIABLE_LINK});
		chk("irq", 32'h1, {31'h0, IRQ});
		errs(2, 1'b0);
		rdc(LINK_ERR_COUNT_OFS, 32'hff, 32'h2, "held count");
		bus(1'b1, MONITOR_CONTROL_OFS, 32'h0);
		bus(1'b1, LINK_UNRELIABLE_OFS, 32'h1);
		bus(1'b1, IRQ_STATUS_OFS, 32'h3);
		repeat (2) @(posedge CORE_CLK);
		@(negedge CORE_CLK);
		chk("cleared flag", 32'h0, {31'h0, UNRELIABLE_LINK});
		chk("cleared irq", 32'h0, {31'h0, IRQ});
	endtask : t_flag
	task automatic t_window;
		bus(1'b1, IRQ_MASK_OFS, 32'h2);
		bus(1'b1, ERR_RATE_THRESH_OFS, {24'h000005, 8'hff});
		LINK_RETRAIN_REQUEST <= 1'b1;
		@(posedge CORE_CLK);
		LINK_RETRAIN_REQUEST <= 1'b0;
		errs(1, 1'b0);
		repeat (40) @(posedge CORE_CLK);
		rdc(LINK_ERR_COUNT_OFS, 32'hff, 32'h0, "window count");
		chk("window wrap", 32'h1, {31'h0, rd[31:8] <= 24'h000005});
		rdc(IRQ_STATUS_OFS, 32'h3, 32'h2, "window irq status");
		@(negedge CORE_CLK);
		chk("window irq", 32'h1, {31'h0, IRQ});
	endtask : t_window
	task automatic complete_run;
		if (num_errors == 0 && total_checks > 0) $display("All checks passed");
		else $display("Checks failed");
		$finish;
	endtask : complete_run
	initial begin
		{SRST, READ, WRITE, LCRC_ERROR, RECOVERY_ERROR} = 5'h10;
		{LINK_RETRAIN_REQUEST, LINK_IN_DETECT} = 2'h0;
		{ADDRESS, WRITEDATA, BYTEENABLE} = {48'h0, 4'hf};
		repeat (16) @(posedge CORE_CLK);
		SRST <= 1'b0;
		t_reset;
		t_sat;
		t_type;
		t_flag;
		t_window;
		complete_run();
	end
	// Whole run is under a thousand cycles
	initial begin
		repeat (20000) @(posedge CORE_CLK);
		num_errors++;
		complete_run();
	end
endmodule : testbench
bind link_error_rate_monitor link_monitor_sva u_link_monitor_sva (
	.CORE_CLK(CORE_CLK), .SRST(SRST), .ADDRESS(ADDRESS), .READ(READ), .WRITE(WRITE),
	.WRITEDATA(WRITEDATA), .BYTEENABLE(BYTEENABLE), .READDATA(READDATA),
	.WAITREQUEST(WAITREQUEST), .IRQ(IRQ), .UNRELIABLE_LINK(UNRELIABLE_LINK),
	.LCRC_ERROR(LCRC_ERROR), .RECOVERY_ERROR(RECOVERY_ERROR),
	.LINK_RETRAIN_REQUEST(LINK_RETRAIN_REQUEST), .LINK_IN_DETECT(LINK_IN_DETECT));
`default_nettype wire
